// File: design/ebr_read_seq.sv
// Read cycle sequencer for a 16-bit non-multiplexed host port target.
`timescale 1ns/1ps
`default_nettype none
`include "ebr_defines.svh"
module ebr_read_seq
    import ebr_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst_b,
    input  wire logic                   rd_req,
    input  wire logic [15:0]            rd_addr,
    input  wire ebr_timing_t            timing,
    input  wire logic                   target_wait_request,
    input  wire logic [15:0]            target_data,
    output ebr_pins_t                   pins,
    output logic                        rd_busy,
    output logic                        rd_done,
    output logic [15:0]                 rd_data
);
    ebr_phase_t  phase_ff;
    ebr_phase_t  nxt_phase;
    logic [4:0]  cnt_ff;
    logic [4:0]  nxt_cnt;
    logic        held_ff;
    logic        nxt_held;
    ebr_timing_t tim_ff;
    ebr_timing_t nxt_tim;
    ebr_pins_t   pins_ff;
    ebr_pins_t   nxt_pins;
    logic        busy_ff;
    logic        nxt_busy;
    logic        done_ff;
    logic        nxt_done;
    logic [15:0] data_ff;
    logic [15:0] nxt_data;
    logic [15:0] tdata_meta_ff;
    logic [15:0] tdata_ff;
    logic        wait_sync;

    // Raise a setting to its floor so a low value cannot break timing.
    function automatic logic [3:0] floor_len(input logic [3:0] v, input logic [3:0] lo);
        floor_len = (v < lo) ? lo : v;
    endfunction

    // Last cycle of a phase whose length is the setting plus one.
    function automatic logic last_cycle(input logic [4:0] c, input logic [3:0] len);
        last_cycle = (c == {1'b0, len});
    endfunction

    ebr_wait_sync u_wait_sync
    (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .async_in (target_wait_request),
        .sync_out (wait_sync)
    );

    // ----------------------------------------
    // Phase sequencer
    // ----------------------------------------
    // Counts run in bus clock periods; the wait only stalls address and strobe.
    always_comb
    begin
        nxt_phase = phase_ff;
        nxt_cnt   = cnt_ff + 5'h01;
        nxt_held  = held_ff;
        nxt_tim   = tim_ff;
        nxt_pins  = pins_ff;
        nxt_busy  = busy_ff;
        nxt_done  = 1'b0;
        nxt_data  = data_ff;
        case (phase_ff)
            EBR_IDLE:
            begin
                nxt_cnt = 5'h00;
                if (rd_req)
                begin
                    nxt_tim.address_phase_len  = floor_len(timing.address_phase_len,
                                                           `EBR_ADDR_LEN_MIN);
                    nxt_tim.setup_phase_len    = floor_len(timing.setup_phase_len,
                                                           `EBR_SETUP_LEN_MIN);
                    nxt_tim.strobe_phase_len   = floor_len(timing.strobe_phase_len,
                                                           `EBR_STROBE_LEN_MIN);
                    nxt_tim.recovery_phase_len = floor_len(timing.recovery_phase_len,
                                                           `EBR_RECOV_LEN_MIN);
                    nxt_pins.chip_select_n = 1'b0;
                    nxt_pins.address       = rd_addr;
                    nxt_busy               = 1'b1;
                    nxt_held               = 1'b0;
                    nxt_phase              = EBR_ADDR;
                end
            end
            EBR_ADDR:
            begin
                if (wait_sync)
                begin
                    nxt_cnt  = cnt_ff;
                    nxt_held = 1'b1;
                end
                else if (held_ff)
                begin
                    nxt_cnt  = cnt_ff;
                    nxt_held = 1'b0;
                end
                else if (last_cycle(cnt_ff, tim_ff.address_phase_len))
                begin
                    nxt_cnt   = 5'h00;
                    nxt_phase = EBR_SETUP;
                end
            end
            EBR_SETUP:
            begin
                if (last_cycle(cnt_ff, tim_ff.setup_phase_len))
                begin
                    nxt_cnt                     = 5'h00;
                    nxt_pins.host_data_strobe_n = 1'b0;
                    nxt_held                    = 1'b0;
                    nxt_phase                   = EBR_STROBE;
                end
            end
            EBR_STROBE:
            begin
                if (wait_sync)
                begin
                    nxt_cnt  = cnt_ff;
                    nxt_held = 1'b1;
                end
                else if (held_ff)
                begin
                    nxt_cnt  = cnt_ff;
                    nxt_held = 1'b0;
                end
                else if (last_cycle(cnt_ff, tim_ff.strobe_phase_len))
                begin
                    nxt_data                    = tdata_ff;
                    nxt_done                    = 1'b1;
                    nxt_pins.host_data_strobe_n = 1'b1;
                    nxt_pins.chip_select_n      = 1'b1;
                    nxt_cnt                     = 5'h00;
                    nxt_phase                   = EBR_RECOV;
                end
            end
            EBR_RECOV:
            begin
                if (last_cycle(cnt_ff, tim_ff.recovery_phase_len))
                begin
                    nxt_cnt   = 5'h00;
                    nxt_busy  = 1'b0;
                    nxt_phase = EBR_IDLE;
                end
            end
            default:
            begin
                nxt_phase = EBR_IDLE;
                nxt_cnt   = 5'h00;
                nxt_busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            phase_ff <= EBR_IDLE;
            cnt_ff   <= 5'h00;
            held_ff  <= 1'b0;
            tim_ff   <= 16'h0000;
            pins_ff  <= {1'b1, 1'b1, 16'h0000};
            busy_ff  <= 1'b0;
            done_ff  <= 1'b0;
            data_ff  <= 16'h0000;
        end
        else
        begin
            phase_ff <= nxt_phase;
            cnt_ff   <= nxt_cnt;
            held_ff  <= nxt_held;
            tim_ff   <= nxt_tim;
            pins_ff  <= nxt_pins;
            busy_ff  <= nxt_busy;
            done_ff  <= nxt_done;
            data_ff  <= nxt_data;
        end
    end

    // ----------------------------------------
    // Read data capture
    // ----------------------------------------
    // The data pins are stable by the window end, but two stages keep them safe.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            tdata_meta_ff <= 16'h0000;
            tdata_ff      <= 16'h0000;
        end
        else
        begin
            tdata_meta_ff <= target_data;
            tdata_ff      <= tdata_meta_ff;
        end
    end

    assign pins    = pins_ff;
    assign rd_busy = busy_ff;
    assign rd_done = done_ff;
    assign rd_data = data_ff;
endmodule
`default_nettype wire

// File: design/ebr_defines.svh
// Timing limits and field widths for the expansion bus read sequencer.
`ifndef EBR_DEFINES_SVH
`define EBR_DEFINES_SVH
// ----------------------------------------
// Phase length settings and field widths
// ----------------------------------------
`define EBR_LEN_W          4
`define EBR_ADDR_LEN_MIN   4'h2
`define EBR_SETUP_LEN_MIN  4'h2
`define EBR_STROBE_LEN_MIN 4'h1
`define EBR_RECOV_LEN_MIN  4'h1
`define EBR_ADDR_W         16
`define EBR_DATA_W         16
`define EBR_CNT_W          5
// ----------------------------------------
// Bus clock figures
// ----------------------------------------
`define EBR_CLK_PERIOD_NS  40
`define EBR_ADDR_VALID_MIN 11
`define EBR_ADDR_VALID_MAX 45
`define EBR_RECOV_MAX      17
`endif

// File: design/ebr_pkg.sv
// Types shared by the expansion bus read sequencer.
package ebr_pkg;
    // Phase encoding, Gray along idle-address-setup-strobe-recovery.
    typedef enum logic [2:0]
    {
        EBR_IDLE   = 3'h0,
        EBR_ADDR   = 3'h1,
        EBR_SETUP  = 3'h3,
        EBR_STROBE = 3'h2,
        EBR_RECOV  = 3'h6
    } ebr_phase_t;

    // Programmed phase lengths.
    typedef struct packed
    {
        logic [3:0] address_phase_len;
        logic [3:0] setup_phase_len;
        logic [3:0] strobe_phase_len;
        logic [3:0] recovery_phase_len;
    } ebr_timing_t;

    // Pins driven toward the target.
    typedef struct packed
    {
        logic        chip_select_n;
        logic        host_data_strobe_n;
        logic [15:0] address;
    } ebr_pins_t;
endpackage

// File: design/ebr_wait_sync.sv
// Two-flop synchroniser for the target wait request pin.
`timescale 1ns/1ps
`default_nettype none
module ebr_wait_sync
(
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_ff;
    logic nxt_meta;
    logic sync_ff;
    logic nxt_sync;

    // ----------------------------------------
    // Synchroniser
    // ----------------------------------------
    // Only the second stage is ever read, to keep metastability contained.
    always_comb
    begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff;
endmodule
`default_nettype wire

// File: test/ebr_read_monitor.sv
// Pin timing checks for the expansion bus read sequencer.
`timescale 1ns/1ps
`default_nettype none
module ebr_read_monitor
    import ebr_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      rst_b,
    input  wire logic      rd_req,
    input  wire ebr_pins_t pins,
    input  wire logic      rd_busy,
    input  wire logic      rd_done,
    input  wire logic      target_wait_request
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // Steps of one access: select opens, strobe opens, strobe closes.
    sequence sel_open;
        $fell(pins.chip_select_n);
    endsequence
    sequence stb_open;
        $fell(pins.host_data_strobe_n);
    endsequence
    chk_take_opens: assert property (rd_req && !rd_busy && !$past(rd_busy)
        && pins.chip_select_n |=> rd_busy && !pins.chip_select_n) else $error("take lost");
    chk_addr_steady: assert property (!pins.chip_select_n && !$fell(pins.chip_select_n)
        |-> $stable(pins.address)) else $error("address moved in access");
    chk_sel_long: assert property (sel_open |-> !pins.chip_select_n[*8])
        else $error("select too short");
    chk_stb_delay: assert property (sel_open |-> pins.host_data_strobe_n[*6])
        else $error("strobe too early");
    chk_stb_width: assert property (stb_open |-> !pins.host_data_strobe_n[*2])
        else $error("strobe too short");
    chk_stb_in_sel: assert property (!pins.host_data_strobe_n |-> !pins.chip_select_n)
        else $error("strobe outside select");
    chk_done_end: assert property ($rose(pins.host_data_strobe_n) |-> rd_done
        && pins.chip_select_n) else $error("done not at strobe end");
    chk_done_pulse: assert property (rd_done |=> !rd_done)
        else $error("done longer than a cycle");
    chk_recov_gap: assert property ($rose(pins.chip_select_n) |-> pins.chip_select_n[*2])
        else $error("recovery gap too short");
    // The wait pin reaches the counter two edges late, so the check looks back two.
    chk_wait_holds: assert property ($past(target_wait_request, 2)
        && !pins.host_data_strobe_n |=> !pins.host_data_strobe_n) else $error("stall ignored");
endmodule
bind ebr_read_seq ebr_read_monitor u_mon (.ref_clk(ref_clk), .rst_b(rst_b), .rd_req(rd_req),
    .pins(pins), .rd_busy(rd_busy), .rd_done(rd_done),
    .target_wait_request(target_wait_request));
`default_nettype wire

// File: test/ebr_dsp_model.sv
// Behavioural host port target that answers reads and can stall.
`timescale 1ns/1ps
`default_nettype none
module ebr_dsp_model
    import ebr_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire ebr_pins_t  pins,
    input  wire logic [3:0] stall_len,
    output logic            target_wait_request,
    output logic [15:0]     target_data
);
    logic [3:0]  stall_ff = 4'h0;
    logic        stb_d_ff = 1'b1;
    logic        cs_d_ff  = 1'b1;
    logic [15:0] junk_ff  = 16'h0f0f;
    // stall on select, strobe
    // A stall is raised just after select and again after the strobe opens, as a slow
    // target would, so both the address and the strobe phase get stretched.
    always @(posedge ref_clk)
    begin
        stb_d_ff <= pins.host_data_strobe_n;
        cs_d_ff  <= pins.chip_select_n;
        junk_ff  <= {junk_ff[14:0], ~junk_ff[15]};
        if ((stb_d_ff && !pins.host_data_strobe_n) || (cs_d_ff && !pins.chip_select_n))
            stall_ff <= stall_len;
        else if (stall_ff != 4'h0)
            stall_ff <= stall_ff - 4'h1;
    end
    assign target_wait_request = (stall_ff != 4'h0);
    // data in window
    // Unselected, the bus scrambles every cycle so a stale value cannot pass.
    assign target_data = !pins.chip_select_n ? (pins.address ^ 16'h3c96) : junk_ff;
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the expansion bus read sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ebr_pkg::*;
;
    logic        ref_clk   = 1'b0;
    logic        rst_b     = 1'b0;
    logic        rd_req    = 1'b0;
    logic [15:0] rd_addr   = 16'h0000;
    ebr_timing_t timing    = 16'h2211;
    logic [3:0]  stall_len = 4'h0;
    logic        target_wait_request;
    logic [15:0] target_data;
    ebr_pins_t   pins;
    logic        rd_busy;
    logic        rd_done;
    logic [15:0] rd_data;
    logic [15:0] exp_q[$];
    ebr_timing_t tab[4] = '{16'h0000, 16'h2211, 16'hffff, 16'h3425};
    int          fails   = 0;
    int          n_tests = 0;
    ebr_read_seq dut (.ref_clk(ref_clk), .rst_b(rst_b), .rd_req(rd_req), .rd_addr(rd_addr),
        .timing(timing), .target_wait_request(target_wait_request),
        .target_data(target_data), .pins(pins), .rd_busy(rd_busy), .rd_done(rd_done),
        .rd_data(rd_data));
    ebr_dsp_model model (.ref_clk(ref_clk), .pins(pins), .stall_len(stall_len),
        .target_wait_request(target_wait_request), .target_data(target_data));
    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic check(input logic ok, input string what);
        n_tests++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Phase length with the floor applied, plus the one extra clock.
    function automatic int ph(input logic [3:0] v, input int m);
        return ((int'(v) < m) ? m : int'(v)) + 1;
    endfunction
    // One read; the request is held one cycle into the access to prove it is refused.
    task automatic do_read(input logic [15:0] a, input ebr_timing_t t, input logic [3:0] st);
        int n;
        int m;
        int len;
        bit to;
        len = ph(t.address_phase_len, 2) + ph(t.setup_phase_len, 2) + ph(t.strobe_phase_len, 1);
        rd_req = 1'b1;
        rd_addr = a;
        timing = t;
        stall_len = st;
        exp_q.push_back(a ^ 16'h3c96);
        for (n = 0; n < 60 && rd_busy !== 1'b1; n++)
            @(negedge ref_clk);
        to = (n >= 60);
        rd_addr = 16'($urandom);
        // Busy shows at the negedge after the take edge, so counting starts at zero there.
        for (n = 0; n < 400 && rd_done !== 1'b1; n++)
        begin
            @(negedge ref_clk);
            rd_req = 1'b0;
        end
        for (m = 0; m < 40 && rd_busy === 1'b1; m++)
            @(negedge ref_clk);
        if (to || n >= 400 || m >= 40)
        begin
            fails++;
            complete_run;
        end
        // A stall of st cycles plus the one release clock stretches each of two phases.
        if (st == 4'h0)
            check(n == len, "access length");
        else
            check(n == len + 2 * (int'(st) + 1), "stall stretch");
        check(m == ph(t.recovery_phase_len, 1), "recovery length");
        $display("read %h took %0d cycles", a, n);
    endtask
    // Every completed read must match the oldest outstanding note.
    always @(posedge ref_clk)
    begin
        #1;
        if (rd_done === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(1'b0, "read without request");
            else
                check(rd_data === exp_q.pop_front(), "read data");
        end
    end
    initial
    begin
        void'($urandom(60448));
        repeat (3) @(negedge ref_clk);
        check(pins === {1'b1, 1'b1, 16'h0000} && rd_data === 16'h0000
            && rd_busy === 1'b0 && rd_done === 1'b0, "reset state");
        rst_b = 1'b1;
        foreach (tab[i])
            do_read(16'($urandom), tab[i], 4'h0);
        repeat (4)
            do_read(16'($urandom), ebr_timing_t'(16'($urandom)), 4'h0);
        // Long address and strobe phases so the synchronised stall lands inside both.
        do_read(16'hbeef, 16'h5351, 4'h6);
        complete_run;
    end
endmodule
`default_nettype wire
